// File: shared/lcp_pkg.sv
// Shared constants and types for the lamp channel PWM control block
`default_nettype none
package lcp_pkg;
    localparam int          NUM_INT          = 4;
    localparam int          NUM_CH           = 5;
    localparam int          EXT_CH           = 4;
    localparam logic [7:0]  DUTY_MIN         = 8'h00;
    localparam logic [7:0]  DUTY_MAX         = 8'hFF;
    localparam logic [7:0]  SKIP_LOW         = 8'hF7;
    localparam logic [7:0]  STEP_4           = 8'h04;
    localparam logic [7:0]  STEP_8           = 8'h08;
    localparam logic [7:0]  STEP_16          = 8'h10;
    localparam logic [7:0]  DUTY_RST         = 8'h00;
    localparam logic [7:0]  SLOW_DUTY_LO     = 8'h04;
    localparam logic [7:0]  SLOW_DUTY_HI     = 8'hFC;
    localparam logic [7:0]  FAST_DUTY_LO     = 8'h08;
    localparam logic [7:0]  FAST_DUTY_HI     = 8'hF8;
    localparam int          DEGLITCH_NS      = 1000;
    localparam int          CLK_NS           = 100;
    localparam int          DEGLITCH_CYC     = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  PRS_DIV4         = 2'b00;
    localparam logic [1:0]  PRS_DIV2         = 2'b01;

    typedef struct packed {
        logic       on;
        logic       global_duty_select;
        logic       input_enable_msb;
        logic       input_enable_lsb;
        logic       pulse_skip_enable;
        logic [1:0] prescale;
        logic [1:0] phase;
        logic [7:0] individual_duty_value;
    } lcp_chan_cfg_t;

    typedef struct packed {
        logic       step_direction;
        logic [3:0] step_code_msb;
        logic [3:0] step_code_lsb;
    } lcp_step_t;
endpackage
`default_nettype wire

// File: rtl/lcp_top.sv
// Lamp channel PWM duty selection, input control, dimming and pulse skipping
`timescale 1ns/1ns
`default_nettype none
module lcp_top
    import lcp_pkg::*;
#(
    parameter int DEGLITCH_CYCLES = DEGLITCH_CYC
)
(
    input  wire logic                          clock,
    input  wire logic                          srst,
    input  wire lcp_pkg::lcp_chan_cfg_t [4:0]  chan_cfg,
    input  wire logic [7:0]                    global_duty,
    input  wire logic                          duty_write,
    input  wire logic [4:0]                    duty_write_mask,
    input  wire logic                          step_write,
    input  wire lcp_pkg::lcp_step_t            step_cmd,
    input  wire logic                          fail_mode,
    input  wire logic [3:0]                    control_input_pins,
    output logic [4:0]                         channel_out,
    output logic [4:0]                         channel_control_signal,
    output logic [3:0]                         window_restart,
    output logic [3:0]                         wake_request,
    output logic [3:0]                         filtered_control_input,
    output logic [4:0][7:0]                    duty_value,
    output logic [4:0]                         duty_in_range
);
    import lcp_pkg::*;

    // ------------------------------------------------------------
    // Period counter and skip slot
    // ------------------------------------------------------------
    logic [7:0] period_cnt;
    logic [2:0] skip_slot;
    logic       period_end;

    assign period_end = (period_cnt == DUTY_MAX);

    always_ff @(posedge clock)
    begin
        if (srst)
            period_cnt <= 8'h00;
        else
            period_cnt <= period_cnt + 8'h01;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            skip_slot <= 3'h0;
        else if (period_end)
            skip_slot <= skip_slot + 3'h1;
    end

    // ------------------------------------------------------------
    // Individual duty registers with saturating steps
    // ------------------------------------------------------------
    logic [4:0][7:0] indiv;

    function automatic logic [7:0] step_amount(input logic [1:0] code);
        case (code)
            2'b01:   step_amount = STEP_4;
            2'b10:   step_amount = STEP_8;
            2'b11:   step_amount = STEP_16;
            default: step_amount = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] step_sat(input logic [7:0] v, input logic [7:0] s,
                                            input logic up);
        logic [8:0] sum;
        sum = 9'h000;
        if (up)
        begin
            sum = {1'b0, v} + {1'b0, s};
            step_sat = sum[8] ? DUTY_MAX : sum[7:0];
        end
        else
            step_sat = (v < s) ? DUTY_MIN : v - s;
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_duty
            always_ff @(posedge clock)
            begin
                if (srst)
                    indiv[g] <= DUTY_RST;
                else if (duty_write && duty_write_mask[g])
                    indiv[g] <= chan_cfg[g].individual_duty_value;
                else if (step_write && g < NUM_INT)
                    indiv[g] <= step_sat(indiv[g],
                        step_amount({step_cmd.step_code_msb[g % NUM_INT],
                                     step_cmd.step_code_lsb[g % NUM_INT]}),
                        step_cmd.step_direction);
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Deglitch filters on the direct inputs
    // ------------------------------------------------------------
    // Input must hold stable for the full count before it passes
    logic [3:0][15:0] dg_cnt;
    logic [3:0]       dg_out;
    logic [3:0]       dg_prev_on;

    generate
        for (g = 0; g < NUM_INT; g++)
        begin : g_dglt
            always_ff @(posedge clock)
            begin
                if (srst)
                begin
                    dg_cnt[g] <= 16'h0000;
                    dg_out[g] <= 1'b0;
                end
                else if (control_input_pins[g] == dg_out[g])
                    dg_cnt[g] <= 16'h0000;
                else if (dg_cnt[g] >= 16'(DEGLITCH_CYCLES - 1))
                begin
                    dg_cnt[g] <= 16'h0000;
                    dg_out[g] <= control_input_pins[g];
                end
                else
                    dg_cnt[g] <= dg_cnt[g] + 16'h0001;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Channel control and duty source
    // ------------------------------------------------------------
    logic [4:0]      next_on;
    logic [4:0]      use_global;
    logic [4:0][7:0] next_duty;
    logic [4:0][7:0] active_duty;

    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            logic inp;
            logic [1:0] en;
            inp = (i < NUM_INT) ? dg_out[i % NUM_INT] : 1'b0;
            en  = {chan_cfg[i].input_enable_msb, chan_cfg[i].input_enable_lsb};
            if (i >= NUM_INT)
                en = 2'b00;
            use_global[i] = chan_cfg[i].global_duty_select;
            if (fail_mode)
                next_on[i] = (i < NUM_INT) && inp;
            else if (!chan_cfg[i].on)
                next_on[i] = 1'b0;
            else
            begin
                case (en)
                    2'b00:   next_on[i] = 1'b1;
                    2'b11:
                    begin
                        next_on[i]    = 1'b1;
                        use_global[i] = chan_cfg[i].global_duty_select ^ inp;
                    end
                    default: next_on[i] = inp;
                endcase
            end
            next_duty[i] = use_global[i] ? global_duty : indiv[i];
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            channel_control_signal <= 5'h00;
        else
            channel_control_signal <= next_on;
    end

    // Full duty and on/off apply at once; partial duty waits for period end
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_act
            always_ff @(posedge clock)
            begin
                if (srst)
                    active_duty[g] <= DUTY_RST;
                else if (period_end || next_duty[g] == DUTY_MAX)
                    active_duty[g] <= next_duty[g];
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (srst)
            window_restart <= 4'h0;
        else
            window_restart <= next_on[3:0] & ~channel_control_signal[3:0];
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            dg_prev_on             <= 4'h0;
            wake_request           <= 4'h0;
            filtered_control_input <= 4'h0;
        end
        else
        begin
            dg_prev_on             <= dg_out;
            wake_request           <= dg_out & ~dg_prev_on;
            filtered_control_input <= dg_out;
        end
    end

    // ------------------------------------------------------------
    // Pulse skipping and compare
    // ------------------------------------------------------------
    // Slot rank: position in the order 0,4,2,6,1,5,3 (slot 7 never skips)
    function automatic logic [2:0] slot_rank(input logic [2:0] s);
        case (s)
            3'd0:    slot_rank = 3'd0;
            3'd4:    slot_rank = 3'd1;
            3'd2:    slot_rank = 3'd2;
            3'd6:    slot_rank = 3'd3;
            3'd1:    slot_rank = 3'd4;
            3'd5:    slot_rank = 3'd5;
            3'd3:    slot_rank = 3'd6;
            default: slot_rank = 3'd7;
        endcase
    endfunction

    logic [4:0][7:0] eff_duty;
    logic [4:0]      skip_active;

    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_out
            logic [7:0] deficit;
            assign deficit = DUTY_MAX - active_duty[g];
            assign skip_active[g] = (g < NUM_INT) && !fail_mode
                && chan_cfg[g].pulse_skip_enable
                && active_duty[g] > SKIP_LOW && active_duty[g] < DUTY_MAX;
            assign eff_duty[g] = !skip_active[g] ? active_duty[g]
                : ({5'h00, slot_rank(skip_slot)} < deficit) ? SKIP_LOW : DUTY_MAX;

            always_ff @(posedge clock)
            begin
                if (srst)
                    channel_out[g] <= 1'b0;
                else
                    channel_out[g] <= next_on[g] &&
                        (eff_duty[g] == DUTY_MAX || period_cnt < eff_duty[g]);
            end

            always_ff @(posedge clock)
            begin
                if (srst)
                begin
                    duty_value[g]    <= DUTY_RST;
                    duty_in_range[g] <= 1'b0;
                end
                else
                begin
                    duty_value[g] <= eff_duty[g];
                    if (chan_cfg[g].prescale == PRS_DIV4)
                        duty_in_range[g] <= eff_duty[g] >= SLOW_DUTY_LO
                                         && eff_duty[g] <= SLOW_DUTY_HI;
                    else
                        duty_in_range[g] <= eff_duty[g] >= FAST_DUTY_LO
                                         && eff_duty[g] <= FAST_DUTY_HI;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    off_when_clear_a: assert property (
        !fail_mode && !chan_cfg[3].on |=> !channel_control_signal[3])
        else $error("channel on with on bit clear");
    ext_fail_off_a: assert property (
        fail_mode |=> !channel_control_signal[EXT_CH])
        else $error("external channel on in fail mode");
    step_sat_up_a: assert property (
        step_write && step_cmd.step_direction && !duty_write && indiv[0] == DUTY_MAX
        |=> indiv[0] == DUTY_MAX)
        else $error("increment wrapped");
    step_sat_dn_a: assert property (
        step_write && !step_cmd.step_direction && !duty_write && indiv[1] == DUTY_MIN
        |=> indiv[1] == DUTY_MIN)
        else $error("decrement wrapped");
    ext_no_step_a: assert property (
        step_write && !duty_write |=> $stable(indiv[EXT_CH]))
        else $error("external duty changed by step");
    slot7_full_a: assert property (
        skip_active[0] && skip_slot == 3'd7 |-> eff_duty[0] == DUTY_MAX)
        else $error("slot 7 skipped");
    ext_no_skip_a: assert property (
        eff_duty[EXT_CH] == active_duty[EXT_CH])
        else $error("skip on external channel");
    restart_edge_a: assert property (
        window_restart[0] |-> channel_control_signal[0] && !$past(channel_control_signal[0]))
        else $error("restart without rising edge");
    duty_hold_a: assert property (
        !period_end && next_duty[2] != DUTY_MAX |=> $stable(active_duty[2]))
        else $error("duty changed mid period");

    skip_cov_c: cover property (skip_active[0] && skip_slot == 3'd3);
    swap_cov_c: cover property (chan_cfg[1].on && chan_cfg[1].input_enable_msb
                                && chan_cfg[1].input_enable_lsb && dg_out[1]);
    step_cov_c: cover property (step_write ##1 step_write);
    fail_cov_c: cover property (fail_mode && window_restart[2]);
endmodule // lcp_top
`default_nettype wire

// File: tb/lcp_pin_model.sv
// Model of the controller side driving the direct control pins
`timescale 1ns/1ns
`default_nettype none
module lcp_pin_model
(
    input  wire logic [3:0] level,
    input  wire logic [3:0] glitch,
    output wire logic [3:0] pins
);
    // Steady level from the controller, with short pulses laid over it on request
    assign pins = level ^ glitch;
endmodule // lcp_pin_model
`default_nettype wire

// File: tb/tb_lcp_top.sv
// Self-checking bench for the lamp channel PWM control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_lcp_top;
    import lcp_pkg::*;
    localparam int DG    = 4;
    localparam int LIMIT = 90000;
    typedef struct packed {logic [2:0] kind; logic [2:0] ch; logic [15:0] exp;} lcp_note_t;
    logic                clock = 1'b0;
    logic                srst  = 1'b1;
    lcp_chan_cfg_t [4:0] chan_cfg;
    lcp_step_t           step_cmd;
    logic [7:0]          global_duty;
    logic                duty_write, step_write, fail_mode, f7_clr, on3, prev3;
    logic [4:0]          duty_write_mask, ctl;
    logic [3:0]          pin_level, glitch, pins, filt;
    logic [4:0]          chan_out, in_rng;
    logic [3:0]          restart, wake, rs_seen, wk_seen;
    logic [4:0][7:0]     duty_value;
    logic [7:0]          ind [5];
    logic [2:0]          probe_ch;
    logic [15:0]         f7_cnt, hi_cnt, got;
    lcp_note_t           notes[$];
    lcp_note_t           cur;
    event                probe_ev;
    int                  failures, check_count, cycles, seed;

    lcp_pin_model u_lcp_pin_model (.level(pin_level), .glitch(glitch), .pins(pins));
    lcp_top #(.DEGLITCH_CYCLES(DG)) u_lcp_top (
        .clock(clock), .srst(srst), .chan_cfg(chan_cfg), .global_duty(global_duty),
        .duty_write(duty_write), .duty_write_mask(duty_write_mask), .step_write(step_write),
        .step_cmd(step_cmd), .fail_mode(fail_mode), .control_input_pins(pins),
        .channel_out(chan_out), .channel_control_signal(ctl), .window_restart(restart),
        .wake_request(wake), .filtered_control_input(filt), .duty_value(duty_value),
        .duty_in_range(in_rng));

    always #50 clock = ~clock;

    // ------------------------------------------------------------
    // Watchers: cycle limit, low-slot counter, note checker
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        cycles++;
        f7_cnt <= f7_clr ? 16'h0000 : f7_cnt + 16'(duty_value[probe_ch] === SKIP_LOW);
        hi_cnt <= f7_clr ? 16'h0000 : hi_cnt + 16'(chan_out[probe_ch]);
        rs_seen <= f7_clr ? 4'h0 : rs_seen | restart;
        wk_seen <= f7_clr ? 4'h0 : wk_seen | wake;
        if (cycles == LIMIT)
        begin
            failures++;
            finish_test();
        end
    end

    always
    begin
        @(probe_ev);
        cur = notes.pop_front();
        case (cur.kind)
            3'd0: got = {8'h00, duty_value[cur.ch]};
            3'd1: got = {11'h000, ctl};
            3'd2: got = {12'h000, filt};
            3'd3: got = f7_cnt;
            3'd4: got = hi_cnt;
            3'd5: got = {8'h00, wk_seen, rs_seen};
            default: got = {11'h000, in_rng};
        endcase
        `CHK(got, cur.exp)
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("Comparisons %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // The #1 lets the watcher re-arm before the next note
    task automatic expect_out(input logic [2:0] k, input logic [2:0] c, input logic [15:0] e);
        notes.push_back({k, c, e});
        -> probe_ev;
        #1;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic write_duty(input logic [4:0] m);
        duty_write_mask = m;
        duty_write = 1'b1;
        wait_n(1);
        duty_write = 1'b0;
    endtask

    task automatic check_duties();
        logic [7:0] d;
        logic [4:0] r;
        for (int c = 0; c < NUM_CH; c++)
        begin
            d = (c == 1) ? global_duty : ind[c];
            expect_out(3'd0, 3'(c), {8'h00, d});
            r[c] = (chan_cfg[c].prescale == PRS_DIV4) ? (d >= SLOW_DUTY_LO && d <= SLOW_DUTY_HI)
                                                      : (d >= FAST_DUTY_LO && d <= FAST_DUTY_HI);
        end
        expect_out(3'd6, 3'd0, {11'h000, r});
    endtask

    // Window of 2048 cycles spans exactly one skip frame at any phase
    task automatic count_f7(input logic [2:0] c);
        probe_ch = c;
        f7_clr = 1'b1;
        wait_n(1);
        f7_clr = 1'b0;
        wait_n(2048);
    endtask

    function automatic logic [7:0] sat_step(logic [7:0] v, logic up, logic [1:0] code);
        logic [8:0] d;
        d = (code == 2'b00) ? 9'd0 : 9'd2 << code;
        if (up)
            return (v + d > 9'h0FF) ? DUTY_MAX : v + d[7:0];
        return (v < d) ? DUTY_MIN : v - d[7:0];
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = $urandom(32'hB6CD7A97);
        chan_cfg = '0;
        step_cmd = '0;
        global_duty = 8'h60;
        {duty_write, step_write, fail_mode, f7_clr} = 4'h0;
        duty_write_mask = 5'h00;
        pin_level = 4'h0;
        glitch = 4'h0;
        probe_ch = 3'd0;
        wait_n(12);
        srst = 1'b0;
        expect_out(3'd1, 3'd0, 16'h0000);
        expect_out(3'd0, 3'd0, 16'h0000);
        for (int i = 0; i < NUM_CH; i++)
        begin
            ind[i] = 8'h20 + 8'($urandom_range(191));
            chan_cfg[i].on = 1'b1;
            chan_cfg[i].individual_duty_value = ind[i];
        end
        chan_cfg[1].global_duty_select = 1'b1;
        write_duty(5'h1F);
        wait_n(540);
        check_duties();
        expect_out(3'd1, 3'd0, 16'h001F);
        for (int s = 0; s < 40; s++)
        begin
            step_cmd.step_direction = (s < 16) ? 1'b1 : (s < 32) ? 1'b0 : 1'($urandom);
            {step_cmd.step_code_msb, step_cmd.step_code_lsb} = (s < 32) ? 8'h77 : 8'($urandom);
            chan_cfg[s % NUM_CH].prescale = 2'($urandom);
            step_write = 1'b1;
            wait_n(1 + (s % 2));
            step_write = 1'b0;
            for (int n = 0; n <= s % 2; n++)
                for (int c = 0; c < NUM_INT; c++)
                    ind[c] = sat_step(ind[c], step_cmd.step_direction,
                                      {step_cmd.step_code_msb[c], step_cmd.step_code_lsb[c]});
            wait_n(540);
            check_duties();
        end
        chan_cfg[2].pulse_skip_enable = 1'b1;
        chan_cfg[4].pulse_skip_enable = 1'b1;
        chan_cfg[4].individual_duty_value = 8'hFD;
        for (int v = 8'hF7; v <= 8'hFF; v++)
        begin
            chan_cfg[2].individual_duty_value = 8'(v);
            write_duty(5'h14);
            wait_n(540);
            count_f7(3'd2);
            expect_out(3'd3, 3'd2, (v == 8'hF7) ? 16'd2048 : 16'((8'hFF - v) * 256));
            expect_out(3'd4, 3'd2, 16'(2048 - 9 * ((v == 8'hF7) ? 8 : 8'hFF - v)));
        end
        count_f7(3'd4);
        expect_out(3'd3, 3'd4, 16'h0000);
        expect_out(3'd4, 3'd4, 16'h07E8);
        chan_cfg[2].individual_duty_value = 8'h03;
        write_duty(5'h04);
        wait_n(540);
        expect_out(3'd0, 3'd2, 16'h0003);
        global_duty = ind[3] ^ 8'hFF;
        chan_cfg[3].input_enable_lsb = 1'b1;
        glitch[3] = 1'b1;
        wait_n(DG - 1);
        glitch[3] = 1'b0;
        wait_n(DG + 2);
        expect_out(3'd2, 3'd3, 16'h0000);
        prev3 = 1'b0;
        for (int k = 0; k < 32; k++)
        begin
            chan_cfg[3].on = ~k[4];
            {chan_cfg[3].input_enable_msb, chan_cfg[3].input_enable_lsb} = k[3:2];
            chan_cfg[3].global_duty_select = k[1];
            pin_level[3] = k[0];
            f7_clr = 1'b1;
            wait_n(1);
            f7_clr = 1'b0;
            wait_n(539);
            on3 = ~k[4] & (k[3:2] == 2'b00 | k[3:2] == 2'b11 | k[0]);
            expect_out(3'd1, 3'd0, {11'h000, 1'b1, on3, 3'b111});
            expect_out(3'd5, 3'd3, {8'h00, k[0], 3'b000, on3 & ~prev3, 3'b000});
            prev3 = on3;
            if (on3)
                expect_out(3'd0, 3'd3, {8'h00, (k[1] ^ (k[3:2] == 2'b11 & k[0]))
                                               ? global_duty : ind[3]});
        end
        fail_mode = 1'b1;
        pin_level = 4'($urandom);
        wait_n(540);
        expect_out(3'd2, 3'd0, {12'h000, pin_level});
        expect_out(3'd1, 3'd0, {11'h000, 1'b0, pin_level});
        wait_n(2);
        finish_test();
    end
endmodule // tb_lcp_top
`default_nettype wire
